// >>> pvc_pkg.sv
// Constants and types shared by the prioritised vectored interrupt controller
package pvc_pkg;
   // Channel count and code width
   localparam int NUM_CH = 16;
   localparam int CODE_W = 4;
   localparam int HALF_CH = 8;

   // Printed register offsets (odd byte addresses)
   localparam logic [7:0] OFF_ENABLE_A = 8'h07;
   localparam logic [7:0] OFF_ENABLE_B = 8'h09;
   localparam logic [7:0] OFF_PENDING_A = 8'h0B;
   localparam logic [7:0] OFF_PENDING_B = 8'h0D;
   localparam logic [7:0] OFF_IN_SERVICE_A = 8'h0F;
   localparam logic [7:0] OFF_IN_SERVICE_B = 8'h11;
   localparam logic [7:0] OFF_MASK_A = 8'h13;
   localparam logic [7:0] OFF_MASK_B = 8'h15;
   localparam logic [7:0] OFF_VECTOR_BASE = 8'h17;

   // Register select codes seen on the five select pins
   localparam logic [4:0] SEL_ENABLE_A = OFF_ENABLE_A[5:1];
   localparam logic [4:0] SEL_ENABLE_B = OFF_ENABLE_B[5:1];
   localparam logic [4:0] SEL_PENDING_A = OFF_PENDING_A[5:1];
   localparam logic [4:0] SEL_PENDING_B = OFF_PENDING_B[5:1];
   localparam logic [4:0] SEL_IN_SERVICE_A = OFF_IN_SERVICE_A[5:1];
   localparam logic [4:0] SEL_IN_SERVICE_B = OFF_IN_SERVICE_B[5:1];
   localparam logic [4:0] SEL_MASK_A = OFF_MASK_A[5:1];
   localparam logic [4:0] SEL_MASK_B = OFF_MASK_B[5:1];
   localparam logic [4:0] SEL_VECTOR_BASE = OFF_VECTOR_BASE[5:1];

   // Vector base register layout and reset values
   localparam int VEC_UPPER_LSB = 4;
   localparam int EOI_SELECT_BIT = 3;
   localparam logic [7:0] VECTOR_BASE_WMASK = 8'hF8;
   localparam logic [7:0] VECTOR_BASE_RESET = 8'h00;
   localparam logic [15:0] CHAN_RESET = 16'h0000;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Bus sequencer states
   typedef enum logic [2:0] {
      PVC_IDLE = 3'b001,
      PVC_ANSWER = 3'b010,
      PVC_PASS = 3'b100
   } pvc_state_t;
endpackage

// >>> pvc_irq_controller.sv
// Sixteen-channel fixed-priority vectored interrupt controller with daisy chain
// Contract
// - Sixteen channels ranked fixed; channel code equals rank, line 7 highest.
// - Acknowledge returns vector of highest pending unmasked channel.
// - Vector bits 7-4 from vector register, bits 3-0 winning channel code.
// - Codes 15-8: line7, line6, timer A, rx full, rx error, tx empty, tx error, timer B.
// - Codes 7-0: line5, line4, timer C, timer D, lines 3 to 0.
// - Pending channels offered in priority order, masked ones skipped.
// - Vector register 8 bits at 0x17, reset zero, bits 2-0 read zero.
// - Select bit 1 software end-of-interrupt; 0 automatic, in-service held zero.
// - Chained devices resolve priority in parallel once acknowledge asserts.
// - With chain-in asserted and need, answer; with chain-in and no need, assert chain-out.
// - Answering device drives vector and keeps chain-out deasserted.
// - Enable bits written 1 enable, 0 disable; registers always readable.
// - Event on enabled channel is recognised and raises request output.
// - Disabled channel ignores events and never sets pending.
// - Writing enable 0 clears pending; request drops unless others pending.
// - Disabling leaves in-service bit; software clears it.
// - Enable A at 0x07 maps codes 15 down to 8, reset zero.
// - Enable B at 0x09 maps codes 7 down to 0, reset zero.
// - Completed acknowledge drops request unless more remain pending.
// - Pending bit clears when its vector is returned.
// - Masked enabled channel still sets pending but cannot request.
// - In-service bit sets on vector delivery while select bit is 1.
`timescale 1ns/1ns
module pvc_irq_controller (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Register bus, active-low strobes
   input wire logic chip_select_n,
   input wire logic data_strobe_n,
   input wire logic read_not_write,
   input wire logic [4:0] reg_select,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic transfer_acknowledge_out_n,
   output logic transfer_acknowledge_oe,
   // Acknowledge cycle and daisy chain
   input wire logic vector_fetch_ack_in_n,
   input wire logic chain_priority_in_n,
   output logic chain_priority_out_n,
   // Open-drain request toward the processor
   output logic interrupt_request_out_n,
   output logic interrupt_request_oe,
   // Channel event pulses, bit index is the channel code
   input wire logic [pvc_pkg::NUM_CH-1:0] channel_event
);
   import pvc_pkg::*;

   pvc_state_t state;
   logic [NUM_CH-1:0] enable;
   logic [NUM_CH-1:0] pending;
   logic [NUM_CH-1:0] mask;
   logic [NUM_CH-1:0] in_service;
   logic [7:0] vector_base_register;
   logic [NUM_CH-1:0] next_enable;
   logic [NUM_CH-1:0] next_pending;
   logic [NUM_CH-1:0] next_mask;
   logic [NUM_CH-1:0] next_in_service;
   logic [7:0] next_vector_base;
   logic [NUM_CH-1:0] requesting;
   logic [CODE_W-1:0] winner;
   logic any_request;
   logic reg_start;
   logic ack_start;
   logic answer_now;
   logic pass_now;
   logic cycle_end;
   logic wr_now;
   logic [NUM_CH-1:0] win_onehot;
   logic [7:0] read_mux;
   logic answered_vector;

   ////////////////////////////////////////////////////////////////////////////
   // Cycle decode; acknowledge cycles take precedence over register access
   assign ack_start = (state == PVC_IDLE) && !vector_fetch_ack_in_n && !data_strobe_n;
   assign reg_start = (state == PVC_IDLE) && vector_fetch_ack_in_n && !chip_select_n
                      && !data_strobe_n;
   assign wr_now = reg_start && !read_not_write;
   // Every device evaluates at once; chain-in only gates who answers
   assign answer_now = ack_start && !chain_priority_in_n && any_request;
   assign pass_now = ack_start && !chain_priority_in_n && !any_request;
   assign cycle_end = data_strobe_n || (chip_select_n && vector_fetch_ack_in_n);

   ////////////////////////////////////////////////////////////////////////////
   // Fixed-priority encoder over unmasked pending channels
   assign requesting = pending & mask;
   assign any_request = |requesting;
   always_comb begin
      winner = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (requesting[i]) begin
            winner = CODE_W'(i);
         end
      end
      win_onehot = '0;
      win_onehot[winner] = answer_now;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next register values; hardware sets win over software and acknowledge clears
   always_comb begin
      next_enable = enable;
      next_mask = mask;
      next_vector_base = vector_base_register;
      next_pending = pending & ~win_onehot;
      next_in_service = in_service;
      if (wr_now) begin
         unique case (reg_select)
            SEL_ENABLE_A: next_enable[15:8] = data_in;
            SEL_ENABLE_B: next_enable[7:0] = data_in;
            SEL_PENDING_A: next_pending[15:8] = next_pending[15:8] & data_in;
            SEL_PENDING_B: next_pending[7:0] = next_pending[7:0] & data_in;
            SEL_IN_SERVICE_A: next_in_service[15:8] = in_service[15:8] & data_in;
            SEL_IN_SERVICE_B: next_in_service[7:0] = in_service[7:0] & data_in;
            SEL_MASK_A: next_mask[15:8] = data_in;
            SEL_MASK_B: next_mask[7:0] = data_in;
            SEL_VECTOR_BASE: next_vector_base = data_in & VECTOR_BASE_WMASK;
            default: next_vector_base = vector_base_register;
         endcase
      end
      // Disabled channels drop pending and ignore events
      next_pending = (next_pending | channel_event) & next_enable;
      if (vector_base_register[EOI_SELECT_BIT]) begin
         next_in_service = next_in_service | win_onehot;
      end
      if (!next_vector_base[EOI_SELECT_BIT]) begin
         next_in_service = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel register state
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         enable <= CHAN_RESET;
         pending <= CHAN_RESET;
         mask <= CHAN_RESET;
         in_service <= CHAN_RESET;
         vector_base_register <= VECTOR_BASE_RESET;
      end else begin
         enable <= next_enable;
         pending <= next_pending;
         mask <= next_mask;
         in_service <= next_in_service;
         vector_base_register <= next_vector_base;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request pin follows the next state so it stays in step with the registers
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         interrupt_request_oe <= 1'b0;
         interrupt_request_out_n <= 1'b0;
      end else begin
         interrupt_request_oe <= |(next_pending & next_mask);
         interrupt_request_out_n <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer; unused vector bits are never stored so read as zero
   always_comb begin
      unique case (reg_select)
         SEL_ENABLE_A: read_mux = enable[15:8];
         SEL_ENABLE_B: read_mux = enable[7:0];
         SEL_PENDING_A: read_mux = pending[15:8];
         SEL_PENDING_B: read_mux = pending[7:0];
         SEL_IN_SERVICE_A: read_mux = in_service[15:8];
         SEL_IN_SERVICE_B: read_mux = in_service[7:0];
         SEL_MASK_A: read_mux = mask[15:8];
         SEL_MASK_B: read_mux = mask[7:0];
         SEL_VECTOR_BASE: read_mux = vector_base_register;
         default: read_mux = UNMAPPED_READ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus sequencer: answer one cycle after the strobe, hold until it is released
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state <= PVC_IDLE;
         data_out <= 8'h00;
         data_oe <= 1'b0;
         transfer_acknowledge_out_n <= 1'b1;
         transfer_acknowledge_oe <= 1'b0;
         chain_priority_out_n <= 1'b1;
         answered_vector <= 1'b0;
      end else begin
         unique case (state)
            PVC_IDLE: begin
               if (answer_now) begin
                  state <= PVC_ANSWER;
                  data_out <= {vector_base_register[7:VEC_UPPER_LSB], winner};
                  data_oe <= 1'b1;
                  transfer_acknowledge_out_n <= 1'b0;
                  transfer_acknowledge_oe <= 1'b1;
                  answered_vector <= 1'b1;
               end else if (pass_now) begin
                  state <= PVC_PASS;
                  chain_priority_out_n <= 1'b0;
               end else if (reg_start) begin
                  state <= PVC_ANSWER;
                  data_out <= read_mux;
                  data_oe <= read_not_write;
                  transfer_acknowledge_out_n <= 1'b0;
                  transfer_acknowledge_oe <= 1'b1;
                  answered_vector <= 1'b0;
               end
            end
            PVC_ANSWER, PVC_PASS: begin
               if (cycle_end) begin
                  state <= PVC_IDLE;
                  data_oe <= 1'b0;
                  transfer_acknowledge_out_n <= 1'b1;
                  transfer_acknowledge_oe <= 1'b0;
                  chain_priority_out_n <= 1'b1;
                  answered_vector <= 1'b0;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the behaviour above
   AST_REQ_EXACT: assert property (@(posedge core_clk) disable iff (reset)
      interrupt_request_oe == |(pending & mask))
      else $error("request pin disagrees with pending and mask");
   AST_DISABLED_IDLE: assert property (@(posedge core_clk) disable iff (reset)
      (pending & ~enable) == 16'h0000)
      else $error("disabled channel holds a pending bit");
   AST_AUTO_EOI_ZERO: assert property (@(posedge core_clk) disable iff (reset)
      !vector_base_register[3] |-> in_service == 16'h0000)
      else $error("in-service bit set in automatic mode");
   AST_VEC_UPPER: assert property (@(posedge core_clk) disable iff (reset)
      answered_vector |-> data_out[7:4] == vector_base_register[7:4])
      else $error("vector upper nibble wrong");
   AST_VEC_WINNER: assert property (@(posedge core_clk) disable iff (reset)
      answer_now |=> data_out[3:0] == $past(winner) && $past(requesting[winner])
         && ($past(requesting) >> 1 >> $past(winner)) == 16'h0000)
      else $error("vector is not the highest pending channel");
   AST_PEND_CLEARED: assert property (@(posedge core_clk) disable iff (reset)
      answer_now && !channel_event[winner] |=> !pending[$past(winner)])
      else $error("pending bit not cleared by acknowledge");
   AST_ISR_SET: assert property (@(posedge core_clk) disable iff (reset)
      answer_now && vector_base_register[3] && !wr_now |=> in_service[$past(winner)])
      else $error("in-service bit not set on delivery");
   AST_CHAIN_QUIET: assert property (@(posedge core_clk) disable iff (reset)
      !chain_priority_out_n |-> !data_oe && !transfer_acknowledge_oe)
      else $error("bus driven while passing priority");
   AST_PASS_ON: assert property (@(posedge core_clk) disable iff (reset)
      pass_now |=> !chain_priority_out_n [*1] ##0 state == PVC_PASS)
      else $error("priority not passed when idle of requests");
   AST_ENABLE_WRITE: assert property (@(posedge core_clk) disable iff (reset)
      wr_now && reg_select == SEL_ENABLE_A |=> enable[15:8] == $past(data_in))
      else $error("enable register A not written");
   AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (reset)
      vector_base_register[2:0] == 3'b000)
      else $error("reserved vector bits not zero");

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, event capture and chain hand-off
   AST_ENABLE_B_WRITE: assert property (@(posedge core_clk) disable iff (reset)
      wr_now && reg_select == SEL_ENABLE_B |=> enable[7:0] == $past(data_in))
      else $error("enable register B not written");
   AST_VECTOR_WRITE: assert property (@(posedge core_clk) disable iff (reset)
      wr_now && reg_select == SEL_VECTOR_BASE
         |=> vector_base_register == ($past(data_in) & VECTOR_BASE_WMASK))
      else $error("vector register not written");
   AST_EVENT_PENDS: assert property (@(posedge core_clk) disable iff (reset)
      !wr_now |=> (pending & $past(channel_event) & $past(enable))
         == ($past(channel_event) & $past(enable)))
      else $error("event on enabled channel not captured");
   AST_DISABLE_CLEARS: assert property (@(posedge core_clk) disable iff (reset)
      wr_now && reg_select == SEL_ENABLE_B |=> (pending[7:0] & ~$past(data_in)) == 8'h00)
      else $error("disabled channel kept its pending bit");
   AST_DISABLE_KEEPS_ISR: assert property (@(posedge core_clk) disable iff (reset)
      wr_now && (reg_select == SEL_ENABLE_A || reg_select == SEL_ENABLE_B)
         |=> $stable(in_service))
      else $error("enable write disturbed in-service bits");
   AST_ACK_DROPS_REQ: assert property (@(posedge core_clk) disable iff (reset)
      answer_now && $onehot(requesting) && channel_event == 16'h0000 |=> !interrupt_request_oe)
      else $error("request kept after last channel was answered");
   AST_CHAIN_SILENT: assert property (@(posedge core_clk) disable iff (reset)
      ack_start && chain_priority_in_n |=> chain_priority_out_n && !data_oe && state == PVC_IDLE)
      else $error("device acted without chain priority");
   AST_ANSWER_NEXT: assert property (@(posedge core_clk) disable iff (reset)
      answer_now |=> !transfer_acknowledge_out_n && data_oe && chain_priority_out_n)
      else $error("vector not answered in the next cycle");
   AST_REG_ACK: assert property (@(posedge core_clk) disable iff (reset)
      reg_start |=> !transfer_acknowledge_out_n && transfer_acknowledge_oe
         && data_oe == $past(read_not_write))
      else $error("register cycle not acknowledged");
   AST_READ_ENABLE_B: assert property (@(posedge core_clk) disable iff (reset)
      reg_start && read_not_write && reg_select == SEL_ENABLE_B
         |=> data_out == $past(enable[7:0]))
      else $error("enable register B read back wrong");
   AST_WINNER_UNMASKED: assert property (@(posedge core_clk) disable iff (reset)
      answer_now |=> mask[data_out[3:0]])
      else $error("masked channel was answered");
   AST_ISR_WRITE_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
      wr_now && reg_select == SEL_IN_SERVICE_B
         |=> in_service[7:0] == ($past(in_service[7:0]) & $past(data_in)))
      else $error("in-service B write did not clear as written");
   AST_PASS_RELEASE: assert property (@(posedge core_clk) disable iff (reset)
      state == PVC_PASS && cycle_end |=> chain_priority_out_n && state == PVC_IDLE)
      else $error("chain priority not released at cycle end");
   AST_REGS_HOLD: assert property (@(posedge core_clk) disable iff (reset)
      !wr_now |=> $stable(enable) && $stable(mask) && $stable(vector_base_register))
      else $error("control register changed without a write");
endmodule

// >>> pvc_host_model.sv
// Host processor model issuing register and vector fetch bus cycles
`timescale 1ns/1ns
module pvc_host_model (
   // Clock
   input wire logic core_clk,
   // Bus cycle toward the controller
   output logic chip_select_n,
   output logic data_strobe_n,
   output logic read_not_write,
   output logic [4:0] reg_select,
   output logic [7:0] data_in,
   output logic vector_fetch_ack_in_n,
   // Answers
   input wire logic transfer_acknowledge_out_n,
   input wire logic chain_priority_out_n
);
   ////////////////////////////////////////////////////////////
   // Idle bus from time zero
   initial begin
      chip_select_n = 1'b1;
      data_strobe_n = 1'b1;
      vector_fetch_ack_in_n = 1'b1;
      read_not_write = 1'b1;
      reg_select = 5'h00;
      data_in = 8'h00;
   end
   // Held until the answer is sampled or wait_max clocks pass, then may linger to act as a slow host;
   // released select, data and direction lines flip so a stale value can never pass for a driven one
   task automatic cycle(input logic fetch, input logic rnw, input logic [4:0] sel,
      input logic [7:0] d, input int wait_max, input int linger, output logic answered);
      answered = 1'b0;
      @(negedge core_clk);
      chip_select_n = fetch;
      vector_fetch_ack_in_n = ~fetch;
      data_strobe_n = 1'b0;
      read_not_write = rnw;
      reg_select = sel;
      data_in = d;
      for (int n = 0; n < wait_max && answered !== 1'b1; n++) begin
         @(posedge core_clk);
         answered = (transfer_acknowledge_out_n === 1'b0) ||
            (fetch === 1'b1 && chain_priority_out_n === 1'b0);
      end
      repeat (linger) @(posedge core_clk);
      @(negedge core_clk);
      chip_select_n = 1'b1;
      data_strobe_n = 1'b1;
      vector_fetch_ack_in_n = 1'b1;
      read_not_write = ~rnw;
      reg_select = ~sel;
      data_in = ~d;
   endtask
endmodule

// >>> pvc_irq_controller_tb.sv
// Self-checking testbench for the vectored interrupt controller
`timescale 1ns/1ns
module pvc_irq_controller_tb;
   import pvc_pkg::*;
   logic core_clk, reset, cs_n, ds_n, rnw, ack_n, ack_oe, ack_in_n, data_oe;
   logic chain_in_n, chain_out_n, irq_n, irq_oe, prev_ack, prev_chain, got;
   logic [4:0] sel;
   logic [7:0] data_in, data_out;
   logic [3:0] nib;
   logic [15:0] evs;
   logic [NUM_CH-1:0] channel_event;
   logic [8:0] exp_q[$];
   int err_count, compares, cycles;
   ////////////////////////////////////////////////////////////
   pvc_irq_controller dut (.core_clk(core_clk), .reset(reset), .chip_select_n(cs_n),
      .data_strobe_n(ds_n), .read_not_write(rnw), .reg_select(sel), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .transfer_acknowledge_out_n(ack_n),
      .transfer_acknowledge_oe(ack_oe), .vector_fetch_ack_in_n(ack_in_n),
      .chain_priority_in_n(chain_in_n), .chain_priority_out_n(chain_out_n),
      .interrupt_request_out_n(irq_n), .interrupt_request_oe(irq_oe),
      .channel_event(channel_event));
   pvc_host_model host (.core_clk(core_clk), .chip_select_n(cs_n), .data_strobe_n(ds_n),
      .read_not_write(rnw), .reg_select(sel), .data_in(data_in),
      .vector_fetch_ack_in_n(ack_in_n), .transfer_acknowledge_out_n(ack_n),
      .chain_priority_out_n(chain_out_n));
   // Clock and a hang guard far above the expected run length
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         end_sim();
      end
   end
   task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("Compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic take(input logic [8:0] seen);
      if (exp_q.size() == 0) begin
         check("unexpected answer", seen, 9'h1FF);
      end else begin
         check("answer", seen, exp_q.pop_front());
      end
   endtask
   // Each answer start (data or chain pass) consumes the oldest note
   always @(posedge core_clk) begin
      if (!reset && ack_n === 1'b0 && prev_ack === 1'b1 && data_oe === 1'b1) begin
         take({1'b0, data_out});
         check("chain out held", {8'h00, chain_out_n}, 9'h001);
         check("ack enable", {8'h00, ack_oe}, 9'h001);
      end
      if (!reset && chain_out_n === 1'b0 && prev_chain === 1'b1) begin
         take(9'h100);
      end
      prev_ack = ack_n;
      prev_chain = chain_out_n;
   end
   task automatic wr(input logic [4:0] s, input logic [7:0] d);
      host.cycle(1'b0, 1'b0, s, d, 8, $urandom_range(2), got);
      check("write ack", {8'h00, got}, 9'h001);
   endtask
   task automatic rd(input logic [4:0] s, input logic [7:0] e);
      exp_q.push_back({1'b0, e});
      host.cycle(1'b0, 1'b1, s, 8'h00, 8, $urandom_range(2), got);
   endtask
   task automatic fetch(input logic [8:0] e);
      exp_q.push_back(e);
      host.cycle(1'b1, 1'b1, 5'h00, 8'h00, 8, $urandom_range(2), got);
   endtask
   task automatic pulse(input logic [15:0] m);
      @(negedge core_clk);
      channel_event = m;
      @(negedge core_clk);
      channel_event = '0;
      @(negedge core_clk);
   endtask
   task automatic irq_is(input logic e);
      check("request", {8'h00, irq_oe}, {8'h00, e});
      check("request level", {8'h00, irq_n}, 9'h000);
   endtask
   // Main sequence
   initial begin
      reset = 1'b1;
      channel_event = '0;
      chain_in_n = 1'b0;
      err_count = 0;
      compares = 0;
      cycles = 0;
      prev_ack = 1'b1;
      prev_chain = 1'b1;
      void'($urandom(32'hD215ECE0));
      repeat (4) @(negedge core_clk);
      reset = 1'b0;
      rd(SEL_VECTOR_BASE, 8'h00);
      rd(SEL_ENABLE_A, 8'h00);
      rd(SEL_ENABLE_B, 8'h00);
      rd(5'h00, UNMAPPED_READ);
      irq_is(1'b0);
      nib = 4'($urandom_range(15));
      wr(SEL_VECTOR_BASE, {nib, 4'h7});
      rd(SEL_VECTOR_BASE, {nib, 4'h0});
      wr(SEL_ENABLE_A, 8'hFF);
      wr(SEL_ENABLE_B, 8'hFF);
      rd(SEL_ENABLE_A, 8'hFF);
      wr(SEL_MASK_A, 8'hFF);
      wr(SEL_MASK_B, 8'hFF);
      // All channels, then a random set: highest code answered first
      for (int r = 0; r < 2; r++) begin
         evs = (r == 0) ? 16'hFFFF : 16'($urandom);
         pulse(evs);
         irq_is(evs != 16'h0000);
         for (int c = 15; c >= 0; c--) begin
            if (evs[c]) fetch({1'b0, nib, 4'(c)});
         end
         irq_is(1'b0);
         fetch(9'h100);
      end
      rd(SEL_IN_SERVICE_A, 8'h00);
      // Masked line seven is skipped but stays pending
      wr(SEL_MASK_A, 8'h7F);
      pulse(16'h8008);
      fetch({1'b0, nib, 4'h3});
      irq_is(1'b0);
      rd(SEL_PENDING_A, 8'h80);
      wr(SEL_MASK_A, 8'hFF);
      @(negedge core_clk);
      irq_is(1'b1);
      fetch({1'b0, nib, 4'hF});
      // Disabled channel ignores events; disabling drops a pending one
      wr(SEL_ENABLE_B, 8'hFE);
      pulse(16'h0001);
      irq_is(1'b0);
      pulse(16'h0002);
      irq_is(1'b1);
      wr(SEL_ENABLE_B, 8'hFC);
      irq_is(1'b0);
      rd(SEL_PENDING_B, 8'h00);
      // Software clears a pending bit by writing zero to it
      pulse(16'h0004);
      irq_is(1'b1);
      wr(SEL_PENDING_B, 8'hFB);
      irq_is(1'b0);
      rd(SEL_PENDING_B, 8'h00);
      rd(SEL_MASK_B, 8'hFF);
      // Software end of interrupt keeps in-service until cleared
      wr(SEL_VECTOR_BASE, {nib, 4'h8});
      pulse(16'h0020);
      fetch({1'b0, nib, 4'h5});
      rd(SEL_IN_SERVICE_B, 8'h20);
      wr(SEL_ENABLE_B, 8'hDC);
      rd(SEL_IN_SERVICE_B, 8'h20);
      wr(SEL_VECTOR_BASE, {nib, 4'h0});
      rd(SEL_IN_SERVICE_B, 8'h00);
      // Without chain priority the device stays silent
      pulse(16'h0040);
      chain_in_n = 1'b1;
      host.cycle(1'b1, 1'b1, 5'h00, 8'h00, 6, 0, got);
      check("silent", {8'h00, got}, 9'h000);
      chain_in_n = 1'b0;
      fetch({1'b0, nib, 4'h6});
      check("notes left", 9'(exp_q.size()), 9'h000);
      end_sim();
   end
endmodule
